// *** hdl/sram_ctrl_regs.vh ***
// Timing and field constants for the asynchronous static memory controller
`ifndef SRAM_CTRL_REGS_VH
`define SRAM_CTRL_REGS_VH

// Pin widths
`define ADDR_W 18
`define DATA_W 8

// Clock period in picoseconds
`define CLK_PERIOD_PS 10000

// Times in picoseconds, as printed in ns
`define READ_CYCLE_PS 10000
`define ADDR_ACCESS_PS 10000
`define WRITE_CYCLE_PS 10000
`define WRITE_PULSE_PS 7000
`define ADDR_SETUP_WEND_PS 7000
`define DATA_SETUP_WEND_PS 5000
`define STROBE_TO_FLOAT_PS 5000
`define OUT_FLOAT_PS 5000
`define WRITE_END_TO_DRIVE_PS 3000

// Least times round up to whole cycles, never below one
`define CYC_UP(t) ((((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
    (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))

`endif

// *** hdl/sram_ctrl.v ***
// Host-side controller for an asynchronous byte-wide static memory
`timescale 1ns/1ps
//
// Functional notes
// RQ1 - Write strobe stays high throughout every read cycle.
// RQ2 - Chip select and output gate stay low while address changes in reads.
// RQ3 - Address is valid before or with chip select falling.
// RQ4 - Memory holds old read data 3 ns after address change.
// RQ5 - Memory drives data no earlier than 3 ns after chip select falls.
// RQ6 - Memory floats data within 5 ns after output gate rises.
// RQ7 - Memory may drive data as soon as output gate falls.
// RQ8 - Address stays stable until write strobe ends; hold 0 ns.
// RQ9 - Address valid at least 7 ns before write end.
// RQ10 - Write data valid at least 5 ns before write end.
// RQ11 - Memory floats data within 5 ns of write strobe falling.
// RQ12 - Memory waits 3 ns after write end before driving again.
// RQ13 - Write timings referenced from last valid address to first transition.
// RQ14 - A write asserts write strobe and chip select together; here chip select falls one cycle before write strobe.
// RQ15 - Memory latches data on first rising edge of strobe or select.
// RQ16 - Memory floats data when select or gate inactive, or strobe active.
// RQ17 - Chip select high means standby; other strobes ignored.
// RQ18 - Memory model holds one byte per address, kept through standby.

`include "sram_ctrl_regs.vh"

module sram_ctrl #(
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W
) (
    input wire clk,
    input wire resetn,
    input wire clkEn,
    input wire reqValid,
    input wire reqWrite,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [DATA_W-1:0] reqWdata,
    output reg reqReady,
    output reg rspValid,
    output reg [DATA_W-1:0] rspRdata,
    output reg [ADDR_W-1:0] memAddr,
    output reg chipSelN,
    output reg writeStrobeN,
    output reg outGateN,
    input wire [DATA_W-1:0] memDataIn,
    output reg [DATA_W-1:0] memDataOut,
    output reg memDataOeN
);

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    // Whole-cycle counts at full integer width
    localparam integer RD_CYC_I = `CYC_UP(`ADDR_ACCESS_PS);
    localparam integer WP_CYC_I = `CYC_UP(`WRITE_PULSE_PS);
    localparam integer FLOAT_CYC_I = `CYC_UP(`STROBE_TO_FLOAT_PS);
    localparam integer OFF_CYC_I = `CYC_UP(`OUT_FLOAT_PS);
    localparam integer REC_CYC_I = `CYC_UP(`WRITE_END_TO_DRIVE_PS);

    // Cut to the counter width; every count stays well below sixteen
    localparam [3:0] RD_CYC = RD_CYC_I[3:0];
    localparam [3:0] WP_CYC = WP_CYC_I[3:0];
    localparam [3:0] FLOAT_CYC = FLOAT_CYC_I[3:0];
    localparam [3:0] OFF_CYC = OFF_CYC_I[3:0];
    localparam [3:0] REC_CYC = REC_CYC_I[3:0];

    // Access wait plus the two synchroniser stages
    localparam [3:0] RD_WAIT = RD_CYC + 4'h2;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_RD = 6'h02;
    localparam [5:0] S_RDOFF = 6'h04;
    localparam [5:0] S_WFLOAT = 6'h08;
    localparam [5:0] S_WPULSE = 6'h10;
    localparam [5:0] S_WREC = 6'h20;

    reg [5:0] state_q;
    reg [3:0] cnt_q;

    // Pins are asynchronous to clk; only the second stage is read
    reg [DATA_W-1:0] dinSync1_q;
    reg [DATA_W-1:0] dinSync2_q;

    // Copy of the request, kept for the whole access
    reg [ADDR_W-1:0] addrHold_q;
    reg [DATA_W-1:0] wdataHold_q;

    // ------------------------------------------------------------
    // Data input synchroniser
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dinSync1_q <= {DATA_W{1'b0}};
            dinSync2_q <= {DATA_W{1'b0}};
        end else if (clkEn) begin
            dinSync1_q <= memDataIn;
            dinSync2_q <= dinSync1_q;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            // Host side ready, no response
            reqReady <= 1'b1;
            rspValid <= 1'b0;
            rspRdata <= {DATA_W{1'b0}};
            // Memory pins parked, data pins released
            memAddr <= {ADDR_W{1'b0}};
            chipSelN <= 1'b1;
            writeStrobeN <= 1'b1;
            outGateN <= 1'b1;
            memDataOut <= {DATA_W{1'b0}};
            memDataOeN <= 1'b1;
            // Request copy
            addrHold_q <= {ADDR_W{1'b0}};
            wdataHold_q <= {DATA_W{1'b0}};
        end else if (clkEn) begin
            // Response pulse lasts one cycle
            rspValid <= 1'b0;
            case (state_q)
                // Requests are taken only here
                S_IDLE: begin
                    if (reqValid) begin
                        reqReady <= 1'b0;
                        addrHold_q <= reqAddr;
                        wdataHold_q <= reqWdata;
                        memAddr <= reqAddr; // [RQ3] [RQ13]
                        chipSelN <= 1'b0; // [RQ3]
                        if (reqWrite) begin
                            // Gate stays high so the memory floats its pins
                            outGateN <= 1'b1; // [RQ16]
                            cnt_q <= FLOAT_CYC;
                            state_q <= S_WFLOAT;
                        end else begin
                            writeStrobeN <= 1'b1; // [RQ1]
                            outGateN <= 1'b0; // [RQ2] [RQ7]
                            cnt_q <= RD_WAIT;
                            state_q <= S_RD;
                        end
                    end
                end

                // Data seen now left the pins two cycles earlier
                S_RD: begin
                    if (cnt_q == 4'h1) begin
                        rspRdata <= dinSync2_q; // [RQ4]
                        rspValid <= 1'b1;
                        chipSelN <= 1'b1; // [RQ17]
                        outGateN <= 1'b1; // [RQ6]
                        cnt_q <= OFF_CYC;
                        state_q <= S_RDOFF;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end

                S_RDOFF: begin
                    // Memory must float before anyone drives the bus again
                    if (cnt_q == 4'h1) begin
                        reqReady <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end

                // Strobe falls on the edge that drives the data; the gate is already high, so the memory floats
                S_WFLOAT: begin
                    writeStrobeN <= 1'b0; // [RQ14]
                    if (cnt_q == 4'h1) begin
                        memDataOut <= wdataHold_q; // [RQ10] [RQ11]
                        memDataOeN <= 1'b0;
                        cnt_q <= WP_CYC;
                        state_q <= S_WPULSE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end

                S_WPULSE: begin
                    if (cnt_q == 4'h1) begin
                        // Both strobes rise together; data and address held
                        writeStrobeN <= 1'b1; // [RQ15]
                        chipSelN <= 1'b1; // [RQ8] [RQ9]
                        cnt_q <= REC_CYC;
                        state_q <= S_WREC;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end

                // Data pins driven one cycle past the write end, then released as recovery ends
                S_WREC: begin
                    memDataOeN <= 1'b1; // [RQ12]
                    memAddr <= addrHold_q;
                    if (cnt_q == 4'h1) begin
                        reqReady <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end

                // Stray state: park the strobes, release the data pins and go idle
                default: begin
                    state_q <= S_IDLE;
                    reqReady <= 1'b1;
                    chipSelN <= 1'b1;
                    writeStrobeN <= 1'b1;
                    outGateN <= 1'b1;
                    memDataOeN <= 1'b1;
                end
            endcase
        end
    end

endmodule // sram_ctrl

// *** test/sram_ctrl_properties.sv ***
// Pin protocol checks for sram_ctrl
`timescale 1ns/1ps
module sram_ctrl_properties #(parameter ADDR_W = 18) (
    input wire clk,
    input wire resetn,
    input wire clkEn,
    input wire reqValid,
    input wire reqWrite,
    input wire [ADDR_W-1:0] reqAddr,
    input wire reqReady,
    input wire rspValid,
    input wire [ADDR_W-1:0] memAddr,
    input wire chipSelN,
    input wire writeStrobeN,
    input wire outGateN,
    input wire memDataOeN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !clkEn);
    sequence s_rd; reqValid && reqReady && !reqWrite; endsequence
    sequence s_wr; reqValid && reqReady && reqWrite; endsequence
    sequence s_pulse; (!chipSelN && !writeStrobeN) ##1 (chipSelN && writeStrobeN); endsequence
    property p_rdWe; s_rd |=> writeStrobeN [*5]; endproperty
    a_rdWe: assert property (p_rdWe) else $error("strobe low in read");
    property p_rdGate; s_rd |=> (!chipSelN && !outGateN) [*3] ##1 (outGateN && rspValid);
    endproperty
    a_rdGate: assert property (p_rdGate) else $error("read gates wrong");
    property p_rdAddr; $fell(chipSelN) |-> memAddr == $past(reqAddr); endproperty
    a_rdAddr: assert property (p_rdAddr) else $error("address late");
    property p_rdRdy; s_rd |=> !reqReady [*4] ##1 reqReady; endproperty
    a_rdRdy: assert property (p_rdRdy) else $error("read ready wrong");
    property p_wrSeq; s_wr |=> (!chipSelN && writeStrobeN) ##1 s_pulse; endproperty
    a_wrSeq: assert property (p_wrSeq) else $error("write pulse wrong");
    property p_addrHold; !chipSelN |=> $stable(memAddr); endproperty
    a_addrHold: assert property (p_addrHold) else $error("address moved");
    property p_wrAddr; $fell(writeStrobeN) |-> !chipSelN && $stable(memAddr); endproperty
    a_wrAddr: assert property (p_wrAddr) else $error("address setup");
    property p_wrData; !writeStrobeN |-> !memDataOeN ##1 !memDataOeN; endproperty
    a_wrData: assert property (p_wrData) else $error("data not driven");
endmodule // sram_ctrl_properties

// *** test/sram_model.sv ***
// Behavioural byte-wide static memory on the data pins
`timescale 1ns/1ps
module sram_model (
    input wire [17:0] addr,
    input wire csN,
    input wire weN,
    input wire oeN,
    input wire [7:0] hostData,
    input wire hostOeN,
    output wire [7:0] bus
);
    reg [7:0] mem [0:262143];
    reg [7:0] last = 8'h00;
    reg drv = 1'b0;
    wire [17:0] rdAddr;
    wire memOn = !csN && weN && !oeN;
    wire wrOn = !csN && !weN;
    assign #3 rdAddr = addr;
    assign bus = !hostOeN ? hostData : (drv ? mem[rdAddr] : ~last);
    always @(memOn) if (memOn) drv <= #3 1'b1; else drv <= #2 1'b0;
    always @(negedge wrOn) mem[addr] = hostData;
    always @(bus) if (!hostOeN || drv) last = bus;
endmodule // sram_model

// *** test/sram_ctrl_test.sv ***
// Self-checking bench for sram_ctrl
`timescale 1ns/1ps
bind sram_ctrl sram_ctrl_properties #(.ADDR_W(ADDR_W)) prop_u (.clk(clk), .resetn(resetn),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqReady(reqReady),
    .clkEn(clkEn), .rspValid(rspValid), .memAddr(memAddr), .chipSelN(chipSelN),
    .writeStrobeN(writeStrobeN), .outGateN(outGateN), .memDataOeN(memDataOeN));
module sram_ctrl_test;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg clkEn = 1'b1;
    reg reqValid = 1'b0;
    reg reqWrite = 1'b0;
    reg [17:0] reqAddr = 18'h00000;
    reg [7:0] reqWdata = 8'h00;
    wire reqReady, rspValid, chipSelN, writeStrobeN, outGateN, memDataOeN;
    wire [7:0] rspRdata, memDataIn, memDataOut;
    wire [17:0] memAddr;
    wire [7:0] idle = {reqReady, chipSelN, writeStrobeN, outGateN, memDataOeN, rspValid, 2'b00};
    reg [34:0] rows [0:7];
    reg [7:0] q;
    integer err_total = 0, checked = 0, i, n;
    always #5 clk = ~clk;
    sram_ctrl dut_u (.clk(clk), .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
        .rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr), .chipSelN(chipSelN),
        .writeStrobeN(writeStrobeN), .outGateN(outGateN), .memDataIn(memDataIn),
        .memDataOut(memDataOut), .memDataOeN(memDataOeN));
    sram_model mem_u (.addr(memAddr), .csN(chipSelN), .weN(writeStrobeN), .oeN(outGateN),
        .hostData(memDataOut), .hostOeN(memDataOeN), .bus(memDataIn));
    task chk(input [8*5:1] what, input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task guard;
        begin
            if (n == 20) begin
                chk("wait", 8'h00, 8'h01);
                summarize;
            end
        end
    endtask
    task xfer(input w, input [17:0] a, input [7:0] d);
        begin
            reqValid <= 1'b1;
            reqWrite <= w;
            reqAddr <= a;
            reqWdata <= d;
            @(posedge clk);
            for (n = 0; n < 20 && reqReady !== 1'b1; n = n + 1) @(posedge clk);
            reqValid <= 1'b0;
            @(posedge clk);
            for (n = n; n < 20 && (w ? reqReady : rspValid) !== 1'b1; n = n + 1)
                @(posedge clk);
            q = rspRdata;
            guard;
        end
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        rows[0] = {1'b1, 18'h00000, 8'ha5, 8'h00};
        rows[1] = {1'b1, 18'h3ffff, 8'h5a, 8'h00};
        rows[2] = {1'b1, 18'h00155, 8'hff, 8'h00};
        rows[3] = {1'b0, 18'h00000, 8'h00, 8'ha5};
        rows[4] = {1'b1, 18'h00155, 8'h00, 8'h00};
        rows[5] = {1'b0, 18'h00155, 8'h00, 8'h00};
        rows[6] = {1'b1, 18'h002aa, 8'h3c, 8'h00};
        rows[7] = {1'b0, 18'h002aa, 8'h00, 8'h3c};
        repeat (3) @(posedge clk);
        chk("reset", idle, 8'hf8);
        resetn <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            xfer(rows[i][34], rows[i][33:16], rows[i][15:8]);
            if (!rows[i][34]) chk("rdata", q, rows[i][7:0]);
        end
        // Freeze mid-read, then resume
        reqValid <= 1'b1;
        reqWrite <= 1'b0;
        reqAddr <= 18'h002aa;
        @(posedge clk);
        reqValid <= 1'b0;
        clkEn <= 1'b0;
        repeat (4) @(posedge clk);
        chk("hold", {5'h00, chipSelN, outGateN, reqReady}, 8'h00);
        clkEn <= 1'b1;
        for (n = 0; n < 20 && rspValid !== 1'b1; n = n + 1) @(posedge clk);
        guard;
        chk("frz", rspRdata, 8'h3c);
        reqValid <= 1'b1;
        reqWrite <= 1'b0;
        reqAddr <= 18'h3ffff;
        @(posedge clk);
        reqValid <= 1'b0;
        @(posedge clk);
        resetn <= 1'b0;
        #1 chk("abort", idle, 8'hf8);
        @(posedge clk);
        resetn <= 1'b1;
        xfer(1'b0, 18'h3ffff, 8'h00);
        chk("keep", q, 8'h5a);
        summarize;
    end
endmodule // sram_ctrl_test
